// ---- src/fcr_cfg.svh ----
`ifndef FCR_CFG_SVH
`define FCR_CFG_SVH

// Result word geometry
`define FCR_WORD_BITS 16
`define FCR_CHANNELS 4
`define FCR_PTR_BITS 2
`define FCR_BIT_CNT_BITS 4
`define FCR_LAST_BIT 4'hF
`define FCR_BYTE_BITS 8

// Serial output B starts two channels ahead of output A
`define FCR_B_OFFSET 2'h2
`define FCR_PTR_FIRST 2'h0

// Parallel read counter
`define FCR_RD_CNT_BITS 3
`define FCR_RD_CNT_RESET 3'h0
`define FCR_RD_CNT_MAX 3'h7
`define FCR_FIRST_READ 3'h1
`define FCR_SECOND_READ 3'h2

// Synchroniser vector: field positions and reset value
`define FCR_SYNC_BITS 6
`define FCR_IDX_CS 0
`define FCR_IDX_RD 1
`define FCR_IDX_SEL 2
`define FCR_IDX_BYTE 3
`define FCR_IDX_HBEN 4
`define FCR_IDX_PTR0 5
`define FCR_SYNC_RESET 6'h23

// Output reset values
`define FCR_OE_OFF 1'b1
`define FCR_FLAG_RESET 1'b0
`define FCR_DATA_RESET 16'h0000

`endif

// ---- src/fcr_pkg.sv ----
`include "fcr_cfg.svh"

package fcr_pkg;

  typedef enum logic [1:0] {
    FCR_MODE_PAR,
    FCR_MODE_SER,
    FCR_MODE_BYTE
  } fcr_mode_t;

  typedef struct packed {
    logic [`FCR_CHANNELS-1:0][`FCR_WORD_BITS-1:0] word;
  } fcr_results_t;

  // Channel index 0 is channel one
  function automatic logic [`FCR_WORD_BITS-1:0] fcr_word(input fcr_results_t res,
                                                        input logic [`FCR_PTR_BITS-1:0] idx);
    fcr_word = res.word[idx];
  endfunction : fcr_word

  function automatic fcr_mode_t fcr_decode_mode(input logic sel, input logic byte_sel);
    if (!sel) begin
      fcr_decode_mode = FCR_MODE_PAR;
    end else if (byte_sel) begin
      fcr_decode_mode = FCR_MODE_BYTE;
    end else begin
      fcr_decode_mode = FCR_MODE_SER;
    end
  endfunction : fcr_decode_mode

endpackage : fcr_pkg

// ---- src/fcr_serial_link.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fcr_cfg.svh"

module fcr_serial_link (
  input wire logic serial_clk_in,
  input wire logic cs_n_in,
  input wire logic reset_n_in,
  input wire fcr_pkg::fcr_results_t results_in,
  input wire logic epoch_in,
  output logic serial_out_a_out,
  output logic serial_out_b_out,
  output logic ptr_zero_out
);

  logic [`FCR_BIT_CNT_BITS-1:0] fall_cnt_reg;
  logic [`FCR_BIT_CNT_BITS-1:0] rise_cnt_reg;
  logic [`FCR_PTR_BITS-1:0] ptr_reg;
  logic [`FCR_PTR_BITS-1:0] ptr_next;
  logic [`FCR_PTR_BITS-1:0] ptr_eff;
  logic epoch_new;
  logic epoch_seen_reg;
  logic ptr_zero_reg;
  logic [`FCR_WORD_BITS-1:0] word_a;
  logic [`FCR_WORD_BITS-1:0] word_b;
  logic [`FCR_BIT_CNT_BITS-1:0] bit_idx;

  // Chip select frames each read, so it clears the bit counters without a clock edge
  always_ff @(negedge serial_clk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      fall_cnt_reg <= '0;
    end else begin
      fall_cnt_reg <= fall_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge serial_clk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      rise_cnt_reg <= '0;
    end else begin
      rise_cnt_reg <= rise_cnt_reg + 1'b1;
    end
  end

  // Epoch flips only at busy fall, when no frame may be open, so it is a static level here;
  // the link clock stops between frames and could not run a synchroniser in time
  always_comb begin
    epoch_new = (epoch_in != epoch_seen_reg);
    ptr_eff = epoch_new ? `FCR_PTR_FIRST : ptr_reg;
    ptr_next = ptr_eff;
    if (!cs_n_in && fall_cnt_reg == `FCR_LAST_BIT) begin
      ptr_next = ptr_eff + 1'b1;
    end
  end

  // Channel pointer survives chip select pulses between channels; new data rewinds it
  always_ff @(negedge serial_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ptr_reg <= `FCR_PTR_FIRST;
      epoch_seen_reg <= 1'b0;
      ptr_zero_reg <= 1'b1;
    end else begin
      ptr_reg <= ptr_next;
      epoch_seen_reg <= epoch_in;
      ptr_zero_reg <= (ptr_next == `FCR_PTR_FIRST);
    end
  end

  // Output B wraps three four one two
  always_comb begin
    word_a = fcr_pkg::fcr_word(results_in, ptr_eff);
    word_b = fcr_pkg::fcr_word(results_in, ptr_eff + `FCR_B_OFFSET);
    bit_idx = `FCR_LAST_BIT - rise_cnt_reg;
  end

  // MSB must appear at the chip select fall with no clock, so these are not registered
  assign serial_out_a_out = word_a[bit_idx];
  assign serial_out_b_out = word_b[bit_idx];
  // New data means channel one is next, before any link clock has run
  assign ptr_zero_out = ptr_zero_reg || epoch_new;

  property p_ptr_step;
    @(negedge serial_clk_in) disable iff (!reset_n_in || cs_n_in)
      (fall_cnt_reg == `FCR_LAST_BIT && !epoch_new)
        |=> (ptr_reg == $past(ptr_reg) + 2'h1);
  endproperty

  ptr_step_a: assert property (p_ptr_step)
    else $error("channel pointer did not advance after sixteen clocks");

endmodule : fcr_serial_link

`default_nettype wire

// ---- src/fcr_top.sv ----
//
// Contract
// - Flag pin floats whenever chip select is high.
// - Serial mode: chip select fall drives flag high for channel one.
// - Serial mode: flag goes low after the sixteenth serial clock fall.
// - Reading all on output B: flag stays low for channel one.
// - Flag high only for channel one on A or three on B.
// - Reads are accepted while busy is high, in every interface mode.
// - Output data registers load new results when busy falls.
// - Channels one, two start on A; three, four start on B.
// - Output B alone delivers three, four, one, two.
// - Byte mode: flag high until both bytes of channel one are read.
`timescale 1ns/1ps
`default_nettype none
`include "fcr_cfg.svh"

module fcr_top (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic rd_sclk_in,
  input wire logic cs_n_in,
  input wire logic interface_select_in,
  input wire logic byte_select_in,
  input wire logic high_byte_first_in,
  input wire logic busy_in,
  input wire fcr_pkg::fcr_results_t results_in,
  output logic first_channel_flag_out,
  output logic first_channel_flag_oe_n_out,
  output logic serial_out_a_out,
  output logic serial_out_b_out,
  output logic serial_oe_n_out,
  output logic [`FCR_WORD_BITS-1:0] parallel_data_out,
  output logic parallel_oe_n_out
);

  logic [`FCR_SYNC_BITS-1:0] sync_meta_reg;
  logic [`FCR_SYNC_BITS-1:0] sync_reg;
  logic cs_s;
  logic rd_s;
  logic ptr_zero_s;
  logic ptr_zero_link;
  logic rd_prev_reg;
  logic rd_fall;
  logic busy_prev_reg;
  logic busy_fall;
  fcr_pkg::fcr_mode_t mode_reg;
  fcr_pkg::fcr_results_t result_reg;
  logic epoch_reg;
  logic [`FCR_RD_CNT_BITS-1:0] rd_cnt_reg;
  logic [`FCR_RD_CNT_BITS-1:0] rd_cnt_next;
  logic par_read;
  logic [`FCR_WORD_BITS-1:0] par_word;
  logic par_high;
  logic [`FCR_WORD_BITS-1:0] par_data_next;
  logic flag_reg;
  logic flag_next;
  logic flag_oe_n_reg;
  logic serial_oe_n_reg;
  logic [`FCR_WORD_BITS-1:0] par_data_reg;
  logic par_oe_n_reg;

  // Pins from the host pass two flops before the control logic here looks at them; the serial link takes chip select and clock raw
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      sync_meta_reg <= `FCR_SYNC_RESET;
      sync_reg <= `FCR_SYNC_RESET;
    end else begin
      sync_meta_reg <= {ptr_zero_link, high_byte_first_in, byte_select_in,
                        interface_select_in, rd_sclk_in, cs_n_in};
      sync_reg <= sync_meta_reg;
    end
  end

  assign cs_s = sync_reg[`FCR_IDX_CS];
  assign rd_s = sync_reg[`FCR_IDX_RD];
  assign ptr_zero_s = sync_reg[`FCR_IDX_PTR0];

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      mode_reg <= fcr_pkg::FCR_MODE_PAR;
    end else begin
      mode_reg <= fcr_pkg::fcr_decode_mode(sync_reg[`FCR_IDX_SEL], sync_reg[`FCR_IDX_BYTE]);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      rd_prev_reg <= 1'b1;
      busy_prev_reg <= 1'b0;
    end else begin
      rd_prev_reg <= rd_s;
      busy_prev_reg <= busy_in;
    end
  end

  assign rd_fall = rd_prev_reg && !rd_s;
  assign busy_fall = busy_prev_reg && !busy_in;

  // Registers stay still apart from that edge, so the serial side reads them directly
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      result_reg <= '0;
      epoch_reg <= 1'b0;
    end else if (busy_fall) begin
      result_reg <= results_in;
      epoch_reg <= !epoch_reg;
    end
  end

  fcr_serial_link u_link (
    .serial_clk_in(rd_sclk_in),
    .cs_n_in(cs_n_in),
    .reset_n_in(reset_n_in),
    .results_in(result_reg),
    .epoch_in(epoch_reg),
    .serial_out_a_out(serial_out_a_out),
    .serial_out_b_out(serial_out_b_out),
    .ptr_zero_out(ptr_zero_link)
  );

  assign par_read = rd_fall && !cs_s && (mode_reg != fcr_pkg::FCR_MODE_SER);

  always_comb begin
    rd_cnt_next = rd_cnt_reg;
    if (busy_fall) begin
      rd_cnt_next = `FCR_RD_CNT_RESET;
    end else if (par_read && rd_cnt_reg != `FCR_RD_CNT_MAX) begin
      rd_cnt_next = rd_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      rd_cnt_reg <= `FCR_RD_CNT_RESET;
    end else begin
      rd_cnt_reg <= rd_cnt_next;
    end
  end

  // Byte mode walks channels two reads at a time; the strap picks which half goes first
  always_comb begin
    par_high = rd_cnt_reg[0] ^ sync_reg[`FCR_IDX_HBEN];
    par_data_next = par_data_reg;
    if (mode_reg == fcr_pkg::FCR_MODE_BYTE) begin
      par_word = fcr_pkg::fcr_word(result_reg, rd_cnt_reg[`FCR_RD_CNT_BITS-1:1]);
      if (par_high) begin
        par_data_next = {{`FCR_BYTE_BITS{1'b0}}, par_word[`FCR_WORD_BITS-1:`FCR_BYTE_BITS]};
      end else begin
        par_data_next = {{`FCR_BYTE_BITS{1'b0}}, par_word[`FCR_BYTE_BITS-1:0]};
      end
    end else begin
      par_word = fcr_pkg::fcr_word(result_reg, rd_cnt_reg[`FCR_PTR_BITS-1:0]);
      par_data_next = par_word;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      par_data_reg <= `FCR_DATA_RESET;
      par_oe_n_reg <= `FCR_OE_OFF;
    end else begin
      if (par_read) begin
        par_data_reg <= par_data_next;
      end
      par_oe_n_reg <= cs_s || rd_s || (mode_reg == fcr_pkg::FCR_MODE_SER);
    end
  end

  always_comb begin
    flag_next = `FCR_FLAG_RESET;
    case (mode_reg)
      // Pointer is off zero when B carries channel one
      fcr_pkg::FCR_MODE_SER: begin
        flag_next = ptr_zero_s;
      end
      fcr_pkg::FCR_MODE_BYTE: begin
        flag_next = (rd_cnt_reg == `FCR_FIRST_READ) || (rd_cnt_reg == `FCR_SECOND_READ);
      end
      fcr_pkg::FCR_MODE_PAR: begin
        flag_next = (rd_cnt_reg == `FCR_FIRST_READ);
      end
      default: begin
        flag_next = `FCR_FLAG_RESET;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      flag_reg <= `FCR_FLAG_RESET;
      flag_oe_n_reg <= `FCR_OE_OFF;
    end else if (cs_s) begin
      flag_reg <= `FCR_FLAG_RESET;
      flag_oe_n_reg <= `FCR_OE_OFF;
    end else begin
      flag_reg <= flag_next;
      flag_oe_n_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      serial_oe_n_reg <= `FCR_OE_OFF;
    end else begin
      serial_oe_n_reg <= cs_s || (mode_reg != fcr_pkg::FCR_MODE_SER);
    end
  end

  assign first_channel_flag_out = flag_reg;
  assign first_channel_flag_oe_n_out = flag_oe_n_reg;
  assign serial_oe_n_out = serial_oe_n_reg;
  assign parallel_data_out = par_data_reg;
  assign parallel_oe_n_out = par_oe_n_reg;

  default clocking cb @(posedge clock_in);
  endclocking

  default disable iff (!reset_n_in);

  sequence s_frame_open;
    (mode_reg == fcr_pkg::FCR_MODE_SER) ##0 $fell(cs_s);
  endsequence

  sequence s_first_word_done;
    (mode_reg == fcr_pkg::FCR_MODE_SER && !cs_s) ##0 $fell(ptr_zero_s);
  endsequence

  sequence s_byte_first_read;
    mode_reg == fcr_pkg::FCR_MODE_BYTE && !cs_s && !busy_fall && par_read
      && rd_cnt_reg <= `FCR_FIRST_READ;
  endsequence

  sequence s_byte_quiet;
    (mode_reg == fcr_pkg::FCR_MODE_BYTE && !cs_s && !par_read && !busy_fall)[*2];
  endsequence

  flag_float_a: assert property (cs_s |=> first_channel_flag_oe_n_out)
    else $error("flag driven while chip select high");

  serial_raise_a: assert property (
    s_frame_open ##0 ptr_zero_s |=> (!first_channel_flag_oe_n_out && first_channel_flag_out))
    else $error("flag not raised at serial frame start");

  serial_other_low_a: assert property (
    (mode_reg == fcr_pkg::FCR_MODE_SER && !ptr_zero_s) |=> !first_channel_flag_out)
    else $error("flag high while channel one is not on output A");

  serial_drop_a: assert property (
    s_first_word_done ##1 !cs_s |-> !first_channel_flag_out)
    else $error("flag still high after first serial word");

  serial_only_one_a: assert property (
    (mode_reg == fcr_pkg::FCR_MODE_SER && $past(mode_reg) == fcr_pkg::FCR_MODE_SER
     && first_channel_flag_out) |-> $past(ptr_zero_s))
    else $error("flag high while first channel not on the line");

  busy_load_a: assert property (busy_fall |=> (result_reg == $past(results_in)))
    else $error("results not loaded at busy fall");

  busy_read_a: assert property (
    (busy_in && par_read && rd_cnt_reg != `FCR_RD_CNT_MAX)
      |=> (rd_cnt_reg == $past(rd_cnt_reg) + 3'h1))
    else $error("read during busy was ignored");

  byte_hold_a: assert property (
    s_byte_first_read ##1 s_byte_quiet |-> first_channel_flag_out)
    else $error("flag dropped before both bytes of channel one");

  word_later_a: assert property (
    (mode_reg == fcr_pkg::FCR_MODE_PAR && !cs_s && rd_cnt_reg > `FCR_FIRST_READ)
      ##1 !cs_s |-> !first_channel_flag_out)
    else $error("flag high for a later channel in word mode");

  word_data_a: assert property (
    (mode_reg == fcr_pkg::FCR_MODE_PAR && par_read && rd_cnt_reg == `FCR_RD_CNT_RESET)
      |=> (parallel_data_out == result_reg.word[0]))
    else $error("first parallel word is not channel one");

endmodule : fcr_top

`default_nettype wire

// ---- dv/fcr_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fcr_host_model (
  input wire logic clk_in,
  input wire logic serial_a_in,
  input wire logic serial_b_in,
  input wire logic flag_in,
  input wire logic [15:0] data_in,
  output logic sclk_out,
  output logic cs_n_out
);
  // Serial clock idles high and only toggles inside a frame
  // A chip select rise at start clears the link bit counters before the first frame
  initial begin
    sclk_out = 1'h1;
    cs_n_out = 1'h0;
    #1;
    cs_n_out = 1'h1;
  end

  task automatic hold_clk(input int n);
    repeat (n) @(posedge clk_in);
    #10;
  endtask : hold_clk

  task automatic select(input logic v);
    cs_n_out = v;
    hold_clk(5);
  endtask : select

  task automatic shift_word(output logic [15:0] a, output logic [15:0] b);
    for (int i = 15; i >= 0; i--) begin
      #80 sclk_out = 1'h0;
      a[i] = serial_a_in;
      b[i] = serial_b_in;
      #80 sclk_out = 1'h1;
    end
  endtask : shift_word

  // Five cycles low and high: above the four-cycle minimum the syncs and flag register need
  task automatic par_read(output logic [15:0] d, output logic f);
    sclk_out = 1'h0;
    hold_clk(5);
    d = data_in;
    f = flag_in;
    sclk_out = 1'h1;
    hold_clk(5);
  endtask : par_read
endmodule : fcr_host_model
`default_nettype wire

// ---- dv/first_channel_flag_readout_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module first_channel_flag_readout_tb;
  localparam logic [63:0] V1 = 64'h4D2E_96A1_1F30_C005;
  localparam logic [63:0] V2 = 64'hE7B1_0A5C_6293_3F48;
  localparam logic [63:0] V3 = 64'h19F6_D38A_B1C4_75E2;
  localparam logic [63:0] V4 = 64'hA6C9_2B57_4E18_8D3F;
  localparam logic [63:0] V5 = 64'h5B84_C7E1_39AD_F062;
  logic clock_in;
  logic reset_n_in;
  logic sel;
  logic bsel;
  logic hbf;
  logic busy;
  fcr_pkg::fcr_results_t res;
  wire logic sclk;
  wire logic cs_n;
  wire logic flag;
  wire logic flag_oe_n;
  wire logic out_a;
  wire logic out_b;
  wire logic ser_oe_n;
  wire logic par_oe_n;
  wire logic [15:0] pdata;
  int mismatches = 0;
  int samples_checked = 0;

  always #50 clock_in = ~clock_in;

  fcr_top dut_u (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .rd_sclk_in(sclk),
    .cs_n_in(cs_n),
    .interface_select_in(sel),
    .byte_select_in(bsel),
    .high_byte_first_in(hbf),
    .busy_in(busy),
    .results_in(res),
    .first_channel_flag_out(flag),
    .first_channel_flag_oe_n_out(flag_oe_n),
    .serial_out_a_out(out_a),
    .serial_out_b_out(out_b),
    .serial_oe_n_out(ser_oe_n),
    .parallel_data_out(pdata),
    .parallel_oe_n_out(par_oe_n)
  );

  fcr_host_model host_u (
    .clk_in(clock_in),
    .serial_a_in(out_a),
    .serial_b_in(out_b),
    .flag_in(flag),
    .data_in(pdata),
    .sclk_out(sclk),
    .cs_n_out(cs_n)
  );

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #10;
  endtask : step

  task automatic mode(input logic s, input logic b, input logic h);
    sel = s;
    bsel = b;
    hbf = h;
    step(4);
  endtask : mode

  task automatic busy_on(input logic [63:0] v);
    busy = 1'h1;
    res = fcr_pkg::fcr_results_t'(v);
    step(4);
  endtask : busy_on

  // no frame is open when busy falls
  task automatic busy_off(input logic [63:0] v);
    busy = 1'h0;
    step(1);
    res = fcr_pkg::fcr_results_t'(~v);
    step(3);
  endtask : busy_off

  task automatic convert(input logic [63:0] v);
    busy_on(v);
    busy_off(v);
  endtask : convert

  task automatic t_reset();
    step(4);
    `CHK({flag, flag_oe_n, ser_oe_n, par_oe_n, pdata}, {4'h7, 16'h0000})
    reset_n_in = 1'h1;
    step(3);
    $display("reset test done");
  endtask : t_reset

  // Gap between words lets the flag settle before it is judged
  task automatic t_serial(input logic [63:0] v, input int n, input logic pulse);
    logic [15:0] a;
    logic [15:0] b;
    for (int w = 0; w < n; w++) begin
      if (pulse || w == 0) host_u.select(1'h0);
      else host_u.hold_clk(6);
      `CHK({flag_oe_n, ser_oe_n, flag}, {2'h0, w == 0})
      host_u.shift_word(a, b);
      `CHK(a, v[16*w+:16])
      `CHK(b, v[16*((w+2)%4)+:16])
      if (pulse || w == n - 1) begin
        host_u.select(1'h1);
        `CHK({flag_oe_n, ser_oe_n}, 2'h3)
      end
    end
    $display("serial read of %0d words done", n);
  endtask : t_serial

  task automatic t_busy_read();
    busy_on(V3);
    t_serial(V2, 1, 1'h0);
    busy_off(V3);
    t_serial(V3, 1, 1'h0);
    $display("read during conversion done");
  endtask : t_busy_read

  task automatic t_par_word();
    logic [15:0] d;
    logic f;
    mode(1'h0, 1'h0, 1'h1);
    convert(V4);
    // Words of the last conversion are read while the next one runs
    busy_on(V1);
    host_u.select(1'h0);
    for (int k = 0; k < 4; k++) begin
      host_u.par_read(d, f);
      `CHK(d, V4[16*k+:16])
      `CHK(f, k == 0)
    end
    host_u.select(1'h1);
    `CHK(flag_oe_n, 1'h1)
    busy_off(V1);
    $display("parallel word read done");
  endtask : t_par_word

  task automatic t_par_byte(input logic h);
    logic [15:0] d;
    logic f;
    logic [15:0] c;
    mode(1'h1, 1'h1, h);
    convert(V5);
    host_u.select(1'h0);
    for (int k = 0; k < 8; k++) begin
      host_u.par_read(d, f);
      c = V5[16*(k/2)+:16];
      `CHK(d, {8'h00, ((k % 2 == 0) == h) ? c[15:8] : c[7:0]})
      `CHK(f, k < 2)
    end
    host_u.select(1'h1);
    $display("byte read done, high byte first %0d", h);
  endtask : t_par_byte

  initial begin
    clock_in = 1'h0;
    reset_n_in = 1'h1;
    sel = 1'h1;
    bsel = 1'h0;
    hbf = 1'h1;
    busy = 1'h0;
    res = '0;
    // A real falling edge, so the link's asynchronous reset takes effect
    #10;
    reset_n_in = 1'h0;
    t_reset();
    convert(V1);
    t_serial(V1, 2, 1'h0);
    convert(V2);
    t_serial(V2, 4, 1'h1);
    t_busy_read();
    t_par_word();
    t_par_byte(1'h1);
    t_par_byte(1'h0);
    stop_test();
  end

  // Whole sequence needs about 60 us; over eight times that means a hang
  initial begin
    #500000;
    mismatches++;
    stop_test();
  end
endmodule : first_channel_flag_readout_tb
`default_nettype wire
